// File: include/mtp_pkg.sv
package mtp_pkg;
    // widths
    localparam int CNT_W = 16;
    localparam int PRE_W = 8;
    localparam int FLG_N = 4;

    // counter presets and reset values
    localparam logic [CNT_W-1:0] CNT_PRESET_HI = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_PRESET_LO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [PRE_W-1:0] PRE_RESET = 8'h00;
    localparam logic [FLG_N-1:0] FLG_RESET = 4'h0;

    // mode_select_field encodings
    localparam logic [2:0] MODE_PWM = 3'h1;
    localparam logic [2:0] MODE_CAPTURE = 3'h2;
    localparam logic [2:0] MODE_DUAL = 3'h3;
    localparam logic [2:0] MODE_CAP_TIMER = 3'h4;

    // clock_selector_register encodings
    localparam logic [2:0] CKS_NONE = 3'h0;
    localparam logic [2:0] CKS_PRESCALED = 3'h1;
    localparam logic [2:0] CKS_EXT_EVENT = 3'h2;
    localparam logic [2:0] CKS_PULSE_ACC = 3'h3;
    localparam logic [2:0] CKS_SLOW = 3'h4;

    // software write targets
    localparam logic [1:0] WR_COUNTER_ONE = 2'h0;
    localparam logic [1:0] WR_COUNTER_TWO = 2'h1;
    localparam logic [1:0] WR_RELOAD_A = 2'h2;
    localparam logic [1:0] WR_RELOAD_B = 2'h3;

    // pending flag positions
    localparam int FLG_A = 0;
    localparam int FLG_B = 1;
    localparam int FLG_C = 2;
    localparam int FLG_D = 3;

    // pulse-train sequencer
    typedef enum logic {mtp_pt_idle, mtp_pt_run} mtp_pt_t;
endpackage

// File: include/mtp_clk_if.sv
`timescale 1ns/10ps
interface mtp_clk_if;
    logic [2:0] sel_one;
    logic [2:0] sel_two;
    logic [7:0] prescale;
    logic pb_event;
    logic pb_level;
    logic tick_one;
    logic tick_two;
    // clock selector side
    modport gen (input sel_one, sel_two, prescale, pb_event, pb_level, output tick_one, tick_two);
    // timer core side
    modport core (output sel_one, sel_two, prescale, pb_event, pb_level, input tick_one, tick_two);
endinterface

// File: rtl/mtp_clksel.sv
`timescale 1ns/10ps
module mtp_clksel
    import mtp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // selector bundle
    mtp_clk_if.gen ck
);
    logic [PRE_W-1:0] pre_cnt;
    logic half;
    wire pre_tick = (pre_cnt == PRE_RESET);

    // one clock source per selector code
    function automatic logic pick(input logic [2:0] sel, input logic pre, input logic slow,
                                  input logic ev, input logic lvl);
        logic t;
        t = 1'b0;
        case (sel)
            CKS_PRESCALED: t = pre;
            CKS_EXT_EVENT: t = ev;
            CKS_PULSE_ACC: t = pre & lvl;
            CKS_SLOW: t = slow;
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    // 8-bit prescaler, divides by prescale+1
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            pre_cnt <= PRE_RESET;
        else if (pre_tick)
            pre_cnt <= ck.prescale;
        else
            pre_cnt <= pre_cnt - 8'h01;
    end

    // halved system clock as enable, only meaningful at 32 MHz
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            half <= 1'b0;
        else
            half <= ~half;
    end

    // selected enables
    assign ck.tick_one = pick(ck.sel_one, pre_tick, half, ck.pb_event, ck.pb_level);
    assign ck.tick_two = pick(ck.sel_two, pre_tick, half, ck.pb_event, ck.pb_level);
endmodule

// File: rtl/mtp_timer.sv
`timescale 1ns/10ps
// Functional notes
// [R01] five modes; 1, 1a and 2 built here, 3 and 4 hold counters
// [R02] two 16-bit down-counters and two 16-bit reload/capture registers
// [R03] 8-bit programmable prescaler divides system clock
// [R04] clock sources: pulse-accumulate, external event, prescaled, slow half clock
// [R05] pwm: counter one reloads alternately from A then B on underflow
// [R06] pwm: pin A toggles on each counter one underflow
// [R07] pin A starting level follows pin_a_output_level
// [R08] stop, reset or pwm entry restarts reload sequence at A
// [R09] each reload sets its own pending flag and gated interrupt
// [R10] pwm: counter two is plain timer, underflow raises interrupt two
// [R11] pulse train needs pwm mode plus pulse_train_enable
// [R12] pulse train: underflow toggles A, decrements counter two, stops at end
// [R13] pulse train: counter two underflow presets to zero, never reloads
// [R14] pulse train yields counter two value plus one pulses
// [R15] pulse train starts on pin B edge or software trigger
// [R16] software triggers only after timer_block_enable is set
// [R17] block disabled at reset; each pulse-train entry restarts at A
// [R18] capture: pin A edge copies counter one to A, pin B to B
// [R19] capture with preset enable loads register then presets counter to ffff
// [R20] capture pulses last at least one system clock
// [R21] capture events and counter one underflow raise enabled interrupts
// [R22] capture: counter one stopped on event clocks, counter two any source
// [R23] pending flags stick until cleared; interrupts follow flag and enable
module mtp_timer
    import mtp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // mode control
    input wire logic timer_block_enable_i,
    input wire logic [2:0] mode_select_field_i,
    input wire logic pulse_train_enable_i,
    input wire logic software_trigger_select_i,
    input wire logic software_trigger_bit_i,
    input wire logic pin_a_output_level_i,
    input wire logic pin_a_edge_select_i,
    input wire logic pin_b_edge_select_i,
    input wire logic pin_a_function_enable_i,
    input wire logic pin_b_function_enable_i,
    // clock selection
    input wire logic [2:0] clock_select_one_i,
    input wire logic [2:0] clock_select_two_i,
    input wire logic [PRE_W-1:0] prescale_i,
    // interrupt enables
    input wire logic pin_a_event_irq_enable_i,
    input wire logic pin_b_event_irq_enable_i,
    input wire logic counter_one_underflow_irq_enable_i,
    input wire logic counter_two_underflow_irq_enable_i,
    // software register writes
    input wire logic wr_en_i,
    input wire logic [1:0] wr_sel_i,
    input wire logic [CNT_W-1:0] wr_data_i,
    // pending flag clear, one bit per flag
    input wire logic [FLG_N-1:0] flag_clear_i,
    // timer pins
    input wire logic timer_pin_a_i,
    input wire logic timer_pin_b_i,
    output logic timer_pin_a_o,
    output logic timer_pin_a_oe_n_o,
    // status
    output logic [CNT_W-1:0] counter_one_o,
    output logic [CNT_W-1:0] counter_two_o,
    output logic [CNT_W-1:0] reload_capture_a_o,
    output logic [CNT_W-1:0] reload_capture_b_o,
    output logic [FLG_N-1:0] pending_o,
    output logic irq_one_o,
    output logic irq_two_o
);
    logic rst_q1;
    logic rst_n;
    logic pa_s1;
    logic pa_s2;
    logic pa_s3;
    logic pb_s1;
    logic pb_s2;
    logic pb_s3;
    logic [2:0] sync_warm;
    logic [CNT_W-1:0] counter_one;
    logic [CNT_W-1:0] counter_two;
    logic [CNT_W-1:0] reload_capture_a;
    logic [CNT_W-1:0] reload_capture_b;
    logic [FLG_N-1:0] pending;
    logic phase_b;
    logic pin_a_out;
    logic pin_a_oe_n;
    logic irq_one;
    logic irq_two;
    mtp_pt_t pt_state;
    mtp_pt_t next_pt_state;

    // down-count shared by both counters
    function automatic logic [CNT_W-1:0] dec(input logic [CNT_W-1:0] v);
        return v - CNT_ONE;
    endfunction

    // edge pick: high select means rising edge
    function automatic logic edge_hit(input logic rise, input logic now, input logic prev);
        return rise ? (now & ~prev) : (~now & prev);
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    // pin synchronisers; third stage only feeds the edge detectors
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {pa_s1, pa_s2, pa_s3} <= 3'h0;
            sync_warm <= 3'h0;
            {pb_s1, pb_s2, pb_s3} <= 3'h0;
        end
        else
        begin
            {pa_s1, pa_s2, pa_s3} <= {timer_pin_a_i, pa_s1, pa_s2};
            sync_warm <= {sync_warm[1:0], 1'b1};
            {pb_s1, pb_s2, pb_s3} <= {timer_pin_b_i, pb_s1, pb_s2};
        end
    end

    // pulses shorter than one clock may be missed by these detectors
    // masked until the third stage holds a real sample, else a pin idling high fakes an edge
    wire pa_edge = sync_warm[2] & edge_hit(pin_a_edge_select_i, pa_s2, pa_s3); // [R20]
    wire pb_edge = sync_warm[2] & edge_hit(pin_b_edge_select_i, pb_s2, pb_s3); // [R15]

    // mode decode; modes 3 and 4 leave both counters frozen
    wire en = timer_block_enable_i; // [R17]
    wire is_pwm = en & (mode_select_field_i == MODE_PWM); // [R01]
    wire is_pt = is_pwm & pulse_train_enable_i; // [R11]
    wire is_pwm1 = is_pwm & ~pulse_train_enable_i;
    wire is_cap = en & (mode_select_field_i == MODE_CAPTURE); // [R01]

    // clock selection for both counters
    mtp_clk_if ck ();
    assign ck.sel_one = clock_select_one_i;
    assign ck.sel_two = clock_select_two_i;
    assign ck.prescale = prescale_i; // [R03]
    assign ck.pb_event = pb_edge;
    assign ck.pb_level = pb_s2;

    mtp_clksel u_clksel (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ck(ck.gen)
    ); // [R04]

    // counter one enable; pin B is busy capturing in mode 2
    wire c1_stopped = (clock_select_one_i == CKS_NONE);
    wire c1_evt_src = (clock_select_one_i == CKS_EXT_EVENT) | (clock_select_one_i == CKS_PULSE_ACC);
    wire c1_src_ok = ~(is_cap & c1_evt_src); // [R22]
    wire pt_running = is_pt & (pt_state == mtp_pt_run);
    wire c1_tick = ck.tick_one & c1_src_ok & (is_pwm1 | is_cap | pt_running); // [R12]
    wire c1_uf = c1_tick & (counter_one == CNT_RESET);
    wire pwm_uf = c1_uf & is_pwm;

    // counter two: own clock, or one step per counter one underflow in pulse train
    wire c2_tick = is_pt ? c1_uf : (ck.tick_two & (is_pwm1 | is_cap)); // [R10] [R12]
    wire c2_uf = c2_tick & (counter_two == CNT_RESET);

    // alternating reload source
    wire [CNT_W-1:0] reload_val = phase_b ? reload_capture_b : reload_capture_a; // [R05]

    // capture events
    wire cap_a = is_cap & pa_edge; // [R18]
    wire cap_b = is_cap & pb_edge; // [R18]
    wire cap_preset = (cap_a & pin_a_function_enable_i) | (cap_b & pin_b_function_enable_i); // [R19]

    // pulse-train start and stop
    wire sw_go = software_trigger_select_i & software_trigger_bit_i; // [R16]
    wire pt_go = is_pt & (software_trigger_select_i ? sw_go : pb_edge); // [R15]
    wire pt_end = pt_running & c1_uf & (counter_two == CNT_RESET); // [R14]

    // software write strobes
    wire wr_c1 = wr_en_i & (wr_sel_i == WR_COUNTER_ONE);
    wire wr_c2 = wr_en_i & (wr_sel_i == WR_COUNTER_TWO);
    wire wr_ra = wr_en_i & (wr_sel_i == WR_RELOAD_A);
    wire wr_rb = wr_en_i & (wr_sel_i == WR_RELOAD_B);

    // counter one: write, then capture preset, then reload, then count
    wire [CNT_W-1:0] next_counter_one =
        wr_c1 ? wr_data_i :
        cap_preset ? CNT_PRESET_HI : // [R19]
        pwm_uf ? reload_val : // [R05]
        c1_tick ? dec(counter_one) : counter_one; // [R02]

    // counter two: zero preset on underflow in pulse train, else wraps to ffff
    wire [CNT_W-1:0] next_counter_two =
        wr_c2 ? wr_data_i :
        (c2_uf & is_pt) ? CNT_PRESET_LO : // [R13]
        c2_tick ? dec(counter_two) : counter_two; // [R02]

    // capture registers sample the count before any preset
    wire [CNT_W-1:0] next_reload_capture_a = wr_ra ? wr_data_i : cap_a ? counter_one : reload_capture_a;
    wire [CNT_W-1:0] next_reload_capture_b = wr_rb ? wr_data_i : cap_b ? counter_one : reload_capture_b;

    // sticky flag sources
    wire set_a = (pwm_uf & ~phase_b) | cap_a; // [R09] [R21]
    wire set_b = (pwm_uf & phase_b) | cap_b; // [R09] [R21]
    wire set_c = c1_uf & is_cap; // [R21]
    wire set_d = c2_uf; // [R10]
    wire [FLG_N-1:0] flag_set = {set_d, set_c, set_b, set_a};

    // set beats clear so an event in the clear cycle survives
    wire [FLG_N-1:0] next_pending = flag_set | (pending & ~flag_clear_i); // [R23]

    // reload sequence restarts at A whenever counting was interrupted
    wire phase_restart = ~is_pwm | c1_stopped | (is_pt & ~pt_running); // [R08] [R17]
    wire next_phase_b = phase_restart ? 1'b0 : pwm_uf ? ~phase_b : phase_b;

    // pin A: idle level from software, toggled on each underflow
    wire pin_a_idle = phase_restart;
    wire next_pin_a = pin_a_idle ? pin_a_output_level_i : // [R07]
                      pwm_uf ? ~pin_a_out : pin_a_out; // [R06] [R12]

    // interrupt lines follow flag and enable
    wire next_irq_one = (pending[FLG_A] & pin_a_event_irq_enable_i) |
                        (pending[FLG_B] & pin_b_event_irq_enable_i) |
                        (pending[FLG_C] & counter_one_underflow_irq_enable_i); // [R09] [R21] [R23]
    wire next_irq_two = pending[FLG_D] & counter_two_underflow_irq_enable_i; // [R10] [R23]

    // pulse-train sequencer
    always_comb
    begin
        next_pt_state = pt_state;
        case (pt_state)
            mtp_pt_idle:
            begin
                if (pt_go)
                    next_pt_state = mtp_pt_run;
            end
            mtp_pt_run:
            begin
                if (pt_end || !is_pt)
                    next_pt_state = mtp_pt_idle; // [R12]
            end
            default: next_pt_state = mtp_pt_idle;
        endcase
    end

    // counters and capture registers
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            counter_one <= CNT_RESET;
            counter_two <= CNT_RESET;
            reload_capture_a <= CNT_RESET;
            reload_capture_b <= CNT_RESET;
        end
        else
        begin
            counter_one <= next_counter_one;
            counter_two <= next_counter_two;
            reload_capture_a <= next_reload_capture_a;
            reload_capture_b <= next_reload_capture_b;
        end
    end

    // sequencing, pin and flags
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pt_state <= mtp_pt_idle;
            phase_b <= 1'b0;
            pin_a_out <= 1'b0;
            pin_a_oe_n <= 1'b1;
            pending <= FLG_RESET;
        end
        else
        begin
            pt_state <= next_pt_state;
            phase_b <= next_phase_b;
            pin_a_out <= next_pin_a;
            pin_a_oe_n <= ~(is_pwm & pin_a_function_enable_i);
            pending <= next_pending;
        end
    end

    // registered interrupts, one cycle behind the flags
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_one <= 1'b0;
            irq_two <= 1'b0;
        end
        else
        begin
            irq_one <= next_irq_one;
            irq_two <= next_irq_two;
        end
    end

    // outputs straight from flops
    assign timer_pin_a_o = pin_a_out;
    assign timer_pin_a_oe_n_o = pin_a_oe_n;
    assign counter_one_o = counter_one;
    assign counter_two_o = counter_two;
    assign reload_capture_a_o = reload_capture_a;
    assign reload_capture_b_o = reload_capture_b;
    assign pending_o = pending;
    assign irq_one_o = irq_one;
    assign irq_two_o = irq_two;
endmodule

// File: sim/mtp_timer_props.sv
`timescale 1ns/10ps
module mtp_timer_props
    import mtp_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // watched controls
    input wire logic [2:0] mode_select_field_i,
    input wire logic pulse_train_enable_i,
    input wire logic [2:0] clock_select_one_i,
    input wire logic pin_a_function_enable_i,
    input wire logic pin_b_function_enable_i,
    input wire logic pin_a_event_irq_enable_i,
    input wire logic pin_b_event_irq_enable_i,
    input wire logic counter_one_underflow_irq_enable_i,
    input wire logic counter_two_underflow_irq_enable_i,
    input wire logic wr_en_i,
    input wire logic [1:0] wr_sel_i,
    input wire logic [CNT_W-1:0] wr_data_i,
    input wire logic [FLG_N-1:0] flag_clear_i,
    // watched outputs
    input wire logic timer_pin_a_o,
    input wire logic timer_pin_a_oe_n_o,
    input wire logic [CNT_W-1:0] counter_one_o,
    input wire logic [CNT_W-1:0] counter_two_o,
    input wire logic [CNT_W-1:0] reload_capture_a_o,
    input wire logic [FLG_N-1:0] pending_o,
    input wire logic irq_one_o,
    input wire logic irq_two_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // gated flag terms, named so $past sees plain signals
    wire logic [2:0] en_one = {counter_one_underflow_irq_enable_i, pin_b_event_irq_enable_i, pin_a_event_irq_enable_i};
    wire logic want_one = |(pending_o[2:0] & en_one);
    wire logic want_two = pending_o[FLG_D] & counter_two_underflow_irq_enable_i;
    wire logic pwm_on = (mode_select_field_i == MODE_PWM);
    // presets off, so only a write could move a stopped counter
    wire logic ev_hold = (mode_select_field_i == MODE_CAPTURE) && !wr_en_i && !pin_a_function_enable_i
        && !pin_b_function_enable_i && (clock_select_one_i == CKS_EXT_EVENT || clock_select_one_i == CKS_PULSE_ACC);

    a_irq_one_gate: assert property (irq_one_o == $past(want_one))
        else $error("irq one does not follow gated flags");
    a_irq_two_gate: assert property (irq_two_o == $past(want_two))
        else $error("irq two does not follow gated flag");
    a_flag_sticky: assert property ((($past(pending_o) & ~$past(flag_clear_i)) & ~pending_o) == 4'h0)
        else $error("pending flag dropped without clear");
    a_write_lands: assert property (wr_en_i && wr_sel_i == WR_RELOAD_A
        |=> reload_capture_a_o == $past(wr_data_i))
        else $error("reload a write lost");
    a_pwm_toggle: assert property (pwm_on && $past(pwm_on) && !pulse_train_enable_i && $rose(pending_o[FLG_A])
        |-> timer_pin_a_o != $past(timer_pin_a_o))
        else $error("pin a did not toggle on reload");
    a_train_zero: assert property (pwm_on && pulse_train_enable_i && $rose(pending_o[FLG_D])
        |-> counter_two_o == CNT_PRESET_LO)
        else $error("counter two not preset to zero");
    a_evclk_hold: assert property ($past(ev_hold) && ev_hold |-> $stable(counter_one_o))
        else $error("counter one moved on event clock in capture");
    a_reset_idle: assert property ($rose(rst_n_i)
        |-> pending_o == FLG_RESET && !irq_one_o && timer_pin_a_oe_n_o)
        else $error("block not idle after reset");
    // main scenarios reached
    c_reload_a: cover property ($rose(pending_o[FLG_A]));
    c_train_end: cover property (pulse_train_enable_i && $rose(pending_o[FLG_D]));
    c_irq_one: cover property ($rose(irq_one_o));
endmodule
bind mtp_timer mtp_timer_props u_props (.*);

// File: sim/mtp_pin_src.sv
`timescale 1ns/10ps
module mtp_pin_src
(
    // clock and pins
    input wire logic clk_i,
    output logic pin_a_o,
    output logic pin_b_o
);
    // both sources idle low
    initial
    begin
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
    end
    // each level held two clocks so a one-clock sampler cannot miss it
    task drive(input bit which, input bit lvl);
        @(posedge clk_i);
        #1;
        if (which)
            pin_b_o = lvl;
        else
            pin_a_o = lvl;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import mtp_pkg::*;
;
    // design inputs
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic timer_block_enable_i = 1'b0, pulse_train_enable_i = 1'b0;
    logic software_trigger_select_i = 1'b0, software_trigger_bit_i = 1'b0;
    logic pin_a_output_level_i = 1'b0, pin_a_edge_select_i = 1'b1, pin_b_edge_select_i = 1'b1;
    logic pin_a_function_enable_i = 1'b0, pin_b_function_enable_i = 1'b0;
    logic [2:0] mode_select_field_i = 3'h0, clock_select_one_i = 3'h0, clock_select_two_i = 3'h0;
    logic [7:0] prescale_i = 8'h00;
    logic pin_a_event_irq_enable_i = 1'b1, pin_b_event_irq_enable_i = 1'b1;
    logic counter_one_underflow_irq_enable_i = 1'b1, counter_two_underflow_irq_enable_i = 1'b1;
    logic wr_en_i = 1'b0;
    logic [1:0] wr_sel_i = 2'h0;
    logic [15:0] wr_data_i = 16'h0000;
    logic [3:0] flag_clear_i = 4'h0;
    wire logic timer_pin_a_i, timer_pin_b_i;
    // design outputs
    logic timer_pin_a_o, timer_pin_a_oe_n_o, irq_one_o, irq_two_o;
    logic [15:0] counter_one_o, counter_two_o, reload_capture_a_o, reload_capture_b_o;
    logic [3:0] pending_o;
    // bench state
    logic pa, pb;
    logic [3:0] q[$];
    logic [3:0] prev = 4'h0;
    logic [15:0] v;
    int errors = 0, tests_run = 0, cyc = 0, n;

    always #10 clk_i = ~clk_i;
    // pin a wire: design wins while it drives
    assign timer_pin_a_i = timer_pin_a_oe_n_o ? pa : timer_pin_a_o;
    assign timer_pin_b_i = pb;
    mtp_timer u_dut (.*);
    mtp_pin_src u_pins (.clk_i(clk_i), .pin_a_o(pa), .pin_b_o(pb));

    task chk_flag(input logic [3:0] e, input logic [3:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("Error %0t flags exp %h got %h", $time, e, g);
        end
    endtask
    task chk_val(input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("Error %0t value exp %h got %h", $time, e, g);
        end
    endtask
    task close_out;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task tick(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    // idle cycle before each write so wr_en never changes twice in a step
    task wr(input logic [1:0] s, input logic [15:0] d);
        tick(1);
        wr_en_i = 1'b1;
        wr_sel_i = s;
        wr_data_i = d;
        tick(1);
        wr_en_i = 1'b0;
    endtask
    task wait_q;
        while (q.size() != 0)
            tick(1);
    endtask

    // each freshly set flag group is matched to the oldest note
    always @(negedge clk_i)
    begin
        if (rst_n_i && (pending_o & ~prev) != 4'h0)
        begin
            if (q.size() == 0)
                chk_flag(4'h0, pending_o & ~prev);
            else
                chk_flag(q.pop_front(), pending_o & ~prev);
        end
        prev = pending_o;
    end
    // hang guard, run needs well under a thousand cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            close_out();
        end
    end

    initial
    begin
        void'($urandom(32'h22b8));
        pin_a_output_level_i = 1'($urandom % 2);
        tick(6);
        rst_n_i = 1'b1;
        tick(4);
        chk_val(16'h0000, counter_one_o);
        chk_flag(4'h1, {3'h0, timer_pin_a_oe_n_o});
        // pwm, reloads alternate a then b, restart after stop
        wr(WR_RELOAD_A, 16'h0002);
        wr(WR_RELOAD_B, 16'h0003);
        wr(WR_COUNTER_ONE, 16'h0001);
        chk_val(16'h0002, reload_capture_a_o);
        flag_clear_i = 4'hf;
        pin_a_function_enable_i = 1'b1;
        prescale_i = 8'h01;
        timer_block_enable_i = 1'b1;
        mode_select_field_i = MODE_PWM;
        q = '{4'h1, 4'h2, 4'h1, 4'h2};
        clock_select_one_i = CKS_PRESCALED;
        wait_q();
        clock_select_one_i = CKS_NONE;
        tick(4);
        chk_flag(4'h0, {3'h0, timer_pin_a_oe_n_o});
        chk_flag({3'h0, pin_a_output_level_i}, {3'h0, timer_pin_a_o});
        q = '{4'h1, 4'h2};
        clock_select_one_i = CKS_PRESCALED;
        wait_q();
        clock_select_one_i = CKS_NONE;
        // pulse train, software start, counter two plus one pulses
        n = int'($urandom % 4);
        wr(WR_RELOAD_A, 16'h0001);
        wr(WR_RELOAD_B, 16'h0001);
        wr(WR_COUNTER_ONE, 16'h0002);
        wr(WR_COUNTER_TWO, 16'(n));
        prescale_i = 8'h00;
        pulse_train_enable_i = 1'b1;
        software_trigger_select_i = 1'b1;
        clock_select_one_i = CKS_PRESCALED;
        for (int i = 0; i <= n; i++)
            q.push_back((i % 2) ? 4'h2 : 4'h1);
        q[n] = q[n] | 4'h8;
        tick(2);
        software_trigger_bit_i = 1'b1;
        tick(1);
        software_trigger_bit_i = 1'b0;
        wait_q();
        tick(6);
        chk_val(16'h0000, counter_two_o);
        chk_flag({3'h0, pin_a_output_level_i}, {3'h0, timer_pin_a_o});
        // pulse train started by pin b, single pulse from a
        software_trigger_select_i = 1'b0;
        q.push_back(4'h9);
        u_pins.drive(1'b1, 1'b1);
        wait_q();
        tick(6);
        // dual capture, preset on a only
        v = 16'($urandom);
        pulse_train_enable_i = 1'b0;
        clock_select_one_i = CKS_PULSE_ACC; // pin b still high, counter one must not move
        pin_b_edge_select_i = 1'b0;
        flag_clear_i = 4'h0;
        mode_select_field_i = MODE_CAPTURE;
        wr(WR_COUNTER_ONE, v);
        q.push_back(4'h1);
        u_pins.drive(1'b0, 1'b1);
        wait_q();
        tick(2);
        chk_val(v, reload_capture_a_o);
        chk_val(CNT_PRESET_HI, counter_one_o);
        chk_flag(4'h1, {3'h0, irq_one_o});
        q.push_back(4'h2);
        u_pins.drive(1'b1, 1'b0);
        wait_q();
        tick(2);
        chk_val(CNT_PRESET_HI, reload_capture_b_o);
        flag_clear_i = 4'hf;
        tick(1);
        flag_clear_i = 4'h0;
        chk_flag(4'h0, pending_o);
        // counter two on slow clock, counter one held on event clock
        pin_a_function_enable_i = 1'b0;
        clock_select_one_i = CKS_EXT_EVENT;
        wr(WR_COUNTER_TWO, 16'h0003);
        q.push_back(4'h8);
        clock_select_two_i = CKS_SLOW;
        wait_q();
        tick(2);
        chk_flag(4'h1, {3'h0, irq_two_o});
        chk_val(CNT_PRESET_HI, counter_one_o);
        close_out();
    end
endmodule
